// ### logic/fmld_limit_sel.sv
module fmld_limit_sel (
  // Inputs
  input  wire logic        limitSel,
  input  wire logic        highCurrent,
  input  wire logic        txMask,
  // Result
  output logic [11:0]      limitMa
);

  always_comb begin
    if (highCurrent && txMask) begin
      limitMa = limitSel ? fmld_pkg::LIM_RHI_MA : fmld_pkg::LIM_RLO_MA; // RULE4
    end else begin
      limitMa = limitSel ? fmld_pkg::LIM_HI_MA : fmld_pkg::LIM_LO_MA; // RULE3
    end
  end

endmodule

// ### logic/fmld_mode_decode.sv
// Overview of operation
// RULE1: Limit select bit picks valley threshold
// RULE2: Limit select writable only in initial shutdown
// RULE3: Normal limit 1250 or 1750 mA
// RULE4: HC and mask high: 250 or 500 mA
// RULE5: Force pin OR force bit selects voltage
// RULE6: Force pin fixes target at 4.95 V
// RULE7: Mode 00 no force: shutdown, load disconnected
// RULE8: Mode 01 no force: DC light, current
// RULE9: Mode 10 no force: flash ready, current
// RULE10: Mode 10, HC: stage off during strobe
// RULE11: 11/x or 00/force: LEDs off, voltage
// RULE12: Mode 01 forced: voltage plus DC light
// RULE13: Mode 10 forced: voltage, flash ready
// RULE14: Mode 10 forced, HC: stage stays on
// RULE15: Mode 11 voltage: safety timer disabled
// RULE16: Outputs registered, reset to shutdown decode
module fmld_mode_decode (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins from outside
  input  wire logic        voltageModeForcePin,
  input  wire logic        highCurrentSelect,
  input  wire logic        txMask,
  input  wire logic        flashStrobe,
  // Decoded outputs
  output logic [1:0]       regulationMode,
  output logic             ledEnable,
  output logic             flashReady,
  output logic             dcLightFromBattery,
  output logic             loadConnected,
  output logic             powerStageOn,
  output logic             safetyTimerEnable,
  output logic [11:0]      currentLimitMa,
  output logic [3:0]       outputVoltageCode,
  output logic             fixedVoutSelect
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fmld_pkg::fmld_reg_t     regMode;
    logic                    ledEn;
    logic                    flashRdy;
    logic                    dcBatt;
    logic                    loadConn;
    logic                    stageOn;
    logic                    timerEn;
  } fmld_dec_t;

  typedef struct packed {
    logic [1:0]              mode;
    logic                    vmForceBit;
    logic                    limitSel;
    logic                    started;
    logic [3:0]              ovCode;
    fmld_pkg::fmld_reg_t     regMode;
    logic                    ledEn;
    logic                    flashRdy;
    logic                    dcBatt;
    logic                    loadConn;
    logic                    stageOn;
    logic                    timerEn;
    logic [11:0]             limitMa;
    logic                    fixedVout;
    logic [31:0]             rdata;
  } fmld_state_t;

  fmld_state_t state_q;
  fmld_state_t state_d;

  logic [2:0]  pinSync;
  logic        forcePin;
  logic        hcSel;
  logic        txMaskS;
  logic        strobe;
  logic        vmForce;
  logic [11:0] limitNow;
  logic        apbWrite;
  logic        apbRead;
  fmld_dec_t   decNow;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  fmld_sync2 #(
    .WIDTH (3)
  ) u_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .asyncIn ({voltageModeForcePin, highCurrentSelect, txMask}),
    .syncOut (pinSync)
  );

  // Strobe goes through its own pair to keep one instance per group
  fmld_sync2 #(
    .WIDTH (1)
  ) u_sync_strobe (
    .clk_sys (clk_sys),
    .srst    (srst),
    .asyncIn (flashStrobe),
    .syncOut (strobe)
  );

  assign forcePin = pinSync[2];
  assign hcSel    = pinSync[1];
  assign txMaskS  = pinSync[0];
  assign vmForce  = forcePin | state_q.vmForceBit; // RULE5

  fmld_limit_sel u_limit (
    .limitSel    (state_q.limitSel), // RULE1
    .highCurrent (hcSel),
    .txMask      (txMaskS),
    .limitMa     (limitNow)
  );

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  assign apbWrite = psel & penable & pwrite;
  assign apbRead  = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;

  function automatic logic [31:0] readMux(input fmld_state_t s, input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      fmld_pkg::CTRL_ADDR: begin
        v[fmld_pkg::MODE_LSB +: 2]   = s.mode;
        v[fmld_pkg::VMFORCE_BIT]     = s.vmForceBit;
        v[fmld_pkg::LIMSEL_BIT]      = s.limitSel;
      end
      fmld_pkg::VOUT_ADDR: begin
        v[fmld_pkg::OVCODE_W-1:0]    = s.ovCode;
      end
      fmld_pkg::STATUS_ADDR: begin
        v[1:0] = s.regMode;
        v[2]   = s.ledEn;
        v[3]   = s.flashRdy;
        v[4]   = s.stageOn;
        v[5]   = s.timerEn;
        v[6]   = s.started;
        v[7]   = s.fixedVout;
      end
      fmld_pkg::LIMIT_ADDR: begin
        v[11:0] = s.limitMa;
      end
      default: begin
        v = '0;
      end
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Every branch sets every field, so no stale decode survives a mode change
  function automatic fmld_dec_t decodeMode(input logic [1:0] mode, input logic forced,
                                           input logic hc, input logic strb);
    fmld_dec_t d;
    d = '0;
    if (!forced) begin
      case (mode)
        fmld_pkg::MODE_OFF: begin
          d.regMode  = fmld_pkg::REG_SHUTDOWN; // RULE7
          d.ledEn    = 1'b0;
          d.flashRdy = 1'b0;
          d.dcBatt   = 1'b0;
          d.loadConn = 1'b0; // RULE7
          d.stageOn  = 1'b0;
          d.timerEn  = 1'b0;
        end
        fmld_pkg::MODE_DC: begin
          d.regMode  = fmld_pkg::REG_CURRENT; // RULE8
          d.ledEn    = 1'b1;
          d.flashRdy = 1'b0;
          d.dcBatt   = 1'b1;
          d.loadConn = 1'b1;
          d.stageOn  = 1'b1;
          d.timerEn  = 1'b1;
        end
        fmld_pkg::MODE_FLASH: begin
          d.regMode  = fmld_pkg::REG_CURRENT; // RULE9
          d.ledEn    = 1'b1;
          d.flashRdy = 1'b1;
          d.dcBatt   = 1'b1;
          d.loadConn = 1'b1;
          // Reservoir capacitor carries the strobe in high-current mode
          d.stageOn  = !(hc && strb); // RULE10
          d.timerEn  = 1'b1;
        end
        default: begin
          d.regMode  = fmld_pkg::REG_VOLTAGE; // RULE11
          d.ledEn    = 1'b0;
          d.flashRdy = 1'b0;
          d.dcBatt   = 1'b0;
          d.loadConn = 1'b1;
          d.stageOn  = 1'b1;
          d.timerEn  = 1'b0; // RULE15
        end
      endcase
    end else begin
      case (mode)
        fmld_pkg::MODE_DC: begin
          d.regMode  = fmld_pkg::REG_VOLTAGE; // RULE6
          d.ledEn    = 1'b1; // RULE12
          d.flashRdy = 1'b0;
          d.dcBatt   = 1'b1;
          d.loadConn = 1'b1;
          d.stageOn  = 1'b1;
          d.timerEn  = 1'b1;
        end
        fmld_pkg::MODE_FLASH: begin
          d.regMode  = fmld_pkg::REG_VOLTAGE;
          d.ledEn    = 1'b1; // RULE13
          d.flashRdy = 1'b1;
          d.dcBatt   = !hc;
          d.loadConn = 1'b1;
          d.stageOn  = 1'b1; // RULE14
          d.timerEn  = 1'b1;
        end
        default: begin
          d.regMode  = fmld_pkg::REG_VOLTAGE;
          d.ledEn    = 1'b0; // RULE11
          d.flashRdy = 1'b0;
          d.dcBatt   = 1'b0;
          d.loadConn = 1'b1;
          d.stageOn  = 1'b1;
          d.timerEn  = 1'b0; // RULE15
        end
      endcase
    end
    return d;
  endfunction

  assign decNow = decodeMode(state_q.mode, vmForce, hcSel, strobe);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (fmld_pkg::MODE_LSB + 2 > fmld_pkg::VMFORCE_BIT) begin
    $error("mode field runs into the force bit");
  end

  if (fmld_pkg::VMFORCE_BIT >= fmld_pkg::LIMSEL_BIT) begin
    $error("force bit must sit below the limit select bit");
  end

  if (fmld_pkg::LIMSEL_BIT > 31) begin
    $error("limit select bit outside the data word");
  end

  if (fmld_pkg::OVCODE_W != 4) begin
    $error("output voltage code must be four bits wide");
  end

  // Reduced limits exist to unload the battery, so they must stay below
  if (fmld_pkg::LIM_RHI_MA >= fmld_pkg::LIM_LO_MA) begin
    $error("reduced limit must stay below the normal limit");
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;

    if (apbWrite && paddr == fmld_pkg::CTRL_ADDR) begin
      state_d.mode       = pwdata[fmld_pkg::MODE_LSB +: 2];
      state_d.vmForceBit = pwdata[fmld_pkg::VMFORCE_BIT];
      // Threshold is frozen once the converter has left initial shutdown
      if (!state_q.started) begin
        state_d.limitSel = pwdata[fmld_pkg::LIMSEL_BIT]; // RULE2
      end
    end
    if (apbWrite && paddr == fmld_pkg::VOUT_ADDR) begin
      state_d.ovCode = pwdata[fmld_pkg::OVCODE_W-1:0];
    end
    if (apbRead) begin
      state_d.rdata = readMux(state_q, paddr);
    end

    // Sticky: the first request to leave shutdown ends the initial state,
    // so a back-to-back write cannot slip a new threshold in behind it
    if (state_d.mode != fmld_pkg::MODE_OFF || state_d.vmForceBit || forcePin) begin
      state_d.started = 1'b1; // RULE2
    end

    state_d.regMode   = decNow.regMode;
    state_d.ledEn     = decNow.ledEn;
    state_d.flashRdy  = decNow.flashRdy;
    state_d.dcBatt    = decNow.dcBatt;
    state_d.loadConn  = decNow.loadConn;
    state_d.stageOn   = decNow.stageOn;
    state_d.timerEn   = decNow.timerEn;
    state_d.fixedVout = forcePin; // RULE6

    state_d.limitMa = limitNow; // RULE3 RULE4
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q           <= '0; // RULE16
      state_q.mode      <= fmld_pkg::MODE_RST;
      state_q.ovCode    <= fmld_pkg::OVCODE_RST;
      state_q.regMode   <= fmld_pkg::REG_SHUTDOWN;
      state_q.limitMa   <= fmld_pkg::LIM_LO_MA;
    end else begin
      state_q <= state_d; // RULE16
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata             = state_q.rdata;
  assign regulationMode     = state_q.regMode;
  assign ledEnable          = state_q.ledEn;
  assign flashReady         = state_q.flashRdy;
  assign dcLightFromBattery = state_q.dcBatt;
  assign loadConnected      = state_q.loadConn;
  assign powerStageOn       = state_q.stageOn;
  assign safetyTimerEnable  = state_q.timerEn;
  assign currentLimitMa     = state_q.limitMa;
  assign outputVoltageCode  = state_q.ovCode;
  assign fixedVoutSelect    = state_q.fixedVout;

endmodule

// ### logic/fmld_pkg.sv
package fmld_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR    = 8'h00;
  localparam logic [7:0] VOUT_ADDR    = 8'h04;
  localparam logic [7:0] STATUS_ADDR  = 8'h08;
  localparam logic [7:0] LIMIT_ADDR   = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_LSB     = 0;
  localparam int VMFORCE_BIT  = 2;
  localparam int LIMSEL_BIT   = 3;
  localparam int STROBE_BIT   = 4;
  localparam int OVCODE_W     = 4;

  // ----------------------------------------------------------------
  // Reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_RST    = 2'h0;
  localparam logic [3:0]  OVCODE_RST  = 4'h0;
  localparam logic [11:0] LIM_LO_MA   = 12'h4E2;
  localparam logic [11:0] LIM_HI_MA   = 12'h6D6;
  localparam logic [11:0] LIM_RLO_MA  = 12'h0FA;
  localparam logic [11:0] LIM_RHI_MA  = 12'h1F4;
  // Voltage target used while the force pin is high, in mV
  localparam logic [12:0] PIN_VOUT_MV = 13'h1356;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_DC    = 2'h1;
  localparam logic [1:0] MODE_FLASH = 2'h2;
  localparam logic [1:0] MODE_VOLT  = 2'h3;

  typedef enum logic [1:0] {
    REG_SHUTDOWN = 2'b00,
    REG_CURRENT  = 2'b01,
    REG_VOLTAGE  = 2'b10
  } fmld_reg_t;

endpackage

// ### logic/fmld_sync2.sv
module fmld_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             srst,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin
    $error("WIDTH must be at least one");
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

// ### verification/fmld_host_model.sv
module fmld_host_model (
  // Clock and bus answer
  input  wire logic        clk_sys,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  // Bus request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // Force pin, high current, mask, strobe
  output logic [3:0]       pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {psel, penable, pwrite, paddr, pwdata, pins} = '0;
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle bus must not show a stale request
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
  task automatic drive(input logic [3:0] p);
    @(posedge clk_sys);
    pins <= p;
  endtask
endmodule

// ### verification/fmld_mode_decode_props.sv
module fmld_mode_decode_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // Pins
  input wire logic        voltageModeForcePin,
  input wire logic        highCurrentSelect,
  input wire logic        txMask,
  input wire logic        flashStrobe,
  // Decoded outputs
  input wire logic [1:0]  regulationMode,
  input wire logic        ledEnable,
  input wire logic        flashReady,
  input wire logic        loadConnected,
  input wire logic        powerStageOn,
  input wire logic        safetyTimerEnable,
  input wire logic [11:0] currentLimitMa,
  input wire logic        fixedVoutSelect
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic hcMask;
  logic volt;
  assign hcMask = highCurrentSelect && txMask;
  assign volt = regulationMode == fmld_pkg::REG_VOLTAGE;
  // Pins take three edges to reach the outputs, so hold them four
  a_reduced_limit:
    assert property (hcMask [*4] |-> currentLimitMa inside {12'h0FA, 12'h1F4})
    else $error("reduced limit not applied");
  a_normal_limit:
    assert property (!hcMask [*4] |-> currentLimitMa inside {12'h4E2, 12'h6D6})
    else $error("normal limit not applied");
  a_pin_forces_volt:
    assert property (voltageModeForcePin [*4] |-> fixedVoutSelect && volt)
    else $error("force pin did not select fixed voltage");
  a_volt_leds_off:
    assert property (volt && !ledEnable |-> !safetyTimerEnable && !flashReady)
    else $error("voltage only decode left timer or flash on");
  a_shutdown_off:
    assert property (regulationMode == fmld_pkg::REG_SHUTDOWN |-> !ledEnable && !loadConnected)
    else $error("shutdown left load or leds on");
  a_flash_needs_led:
    assert property (flashReady |-> ledEnable && regulationMode != fmld_pkg::REG_SHUTDOWN)
    else $error("flash ready without leds");
  a_strobe_gate:
    assert property ((regulationMode == fmld_pkg::REG_CURRENT && flashReady
      && highCurrentSelect && flashStrobe) [*4] |-> !powerStageOn)
    else $error("stage on during strobe");
  a_forced_stage_on:
    assert property ((volt && flashReady && highCurrentSelect) [*4] |-> powerStageOn)
    else $error("stage off in forced flash mode");
  a_reset_decode:
    assert property ($past(srst) |-> regulationMode == 2'h0 && currentLimitMa == 12'h4E2
      && !ledEnable)
    else $error("outputs not at shutdown after reset");
endmodule

bind fmld_mode_decode fmld_mode_decode_props u_props (
  .clk_sys(clk_sys), .srst(srst), .voltageModeForcePin(voltageModeForcePin),
  .highCurrentSelect(highCurrentSelect), .txMask(txMask), .flashStrobe(flashStrobe),
  .regulationMode(regulationMode), .ledEnable(ledEnable), .flashReady(flashReady),
  .loadConnected(loadConnected), .powerStageOn(powerStageOn),
  .safetyTimerEnable(safetyTimerEnable), .currentLimitMa(currentLimitMa),
  .fixedVoutSelect(fixedVoutSelect)
);

// ### verification/fmld_mode_decode_tb_top.sv
module fmld_mode_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pins;
  logic [1:0]  regulationMode;
  logic        ledEnable, flashReady, dcLightFromBattery, loadConnected;
  logic        powerStageOn, safetyTimerEnable, fixedVoutSelect;
  logic [11:0] currentLimitMa;
  logic [3:0]  outputVoltageCode;
  int          fail_count = 0;
  int          num_checks = 0;
  // {mode, force bit, force pin, regMode, led, flash, timer, fixed}
  logic [9:0]  rows [10] = '{10'h11A, 10'h21E, 10'h320, 10'h0A0, 10'h1AA,
                             10'h2AE, 10'h3A0, 10'h061, 10'h361, 10'h000};

  always #2 clk_sys = ~clk_sys;

  fmld_host_model host (.clk_sys, .pready, .prdata, .psel, .penable, .pwrite, .paddr,
                        .pwdata, .pins);
  fmld_mode_decode dut (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .voltageModeForcePin(pins[3]), .highCurrentSelect(pins[2]),
    .txMask(pins[1]), .flashStrobe(pins[0]), .regulationMode, .ledEnable, .flashReady,
    .dcLightFromBattery, .loadConnected, .powerStageOn, .safetyTimerEnable,
    .currentLimitMa, .outputVoltageCode, .fixedVoutSelect);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd);
  endtask
  // Pins need three edges, writes two; four covers both
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    check(regulationMode, 2'h0);
    check(currentLimitMa, 12'h4E2);
    check(loadConnected, 1'b0);
    host.xfer(1'b0, 8'h00, 32'h0, rd);
    check(rd, 32'h0);
    // Limit select only taken on the first write out of shutdown
    for (int i = 0; i < 10; i++) begin
      host.drive({rows[i][6], 3'h0});
      wr(8'h00, {28'h0, i == 0, rows[i][7], rows[i][9:8]});
      settle();
      check({regulationMode, ledEnable, flashReady, safetyTimerEnable, fixedVoutSelect},
            rows[i][5:0]);
      check(currentLimitMa, 12'h6D6);
      check(loadConnected, rows[i][5:4] != 2'h0);
    end
    wr(8'h04, 32'hB);
    host.drive(4'h5);
    wr(8'h00, 32'h2);
    settle();
    check(powerStageOn, 1'b0);
    check(currentLimitMa, 12'h6D6);
    check(dcLightFromBattery, 1'b1);
    check(outputVoltageCode, 4'hB);
    host.drive(4'h6);
    settle();
    check(powerStageOn, 1'b1);
    check(currentLimitMa, 12'h1F4);
    host.xfer(1'b0, 8'h0C, 32'h0, rd);
    check(rd, 32'h1F4);
    host.xfer(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h0);
    check({pready, pslverr}, 2'h2);
    wr(8'h00, 32'h6);
    host.drive(4'h5);
    settle();
    check(powerStageOn, 1'b1);
    check(regulationMode, 2'h2);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    check(currentLimitMa, 12'h4E2);
    host.drive(4'h6);
    wr(8'h00, 32'h2);
    settle();
    check(currentLimitMa, 12'h0FA);
    wr(8'h00, 32'hA);
    settle();
    check(currentLimitMa, 12'h0FA);
    // Flash mode, strobe low: current, leds, flash, stage, timer, started
    host.xfer(1'b0, 8'h08, 32'h0, rd);
    check(rd, 32'h7D);
    stop_test();
  end
endmodule
